/* File: hw/spd_prot_map.svh */
/*
 Constants for the serial presence detect EEPROM protection and read
 logic. Assumes it is included by its bare name from the package and
 from both ends.
*/
`ifndef SPD_PROT_MAP_SVH
`define SPD_PROT_MAP_SVH

`define FIX_MEMORY 4'ha
`define FIX_PROTECT 4'h6
`define LOWER_HALF_TOP 8'h7f
`define MEM_BYTES 256
`define WRITE_TIME_NS 5000
`define CLK_PERIOD_NS 5
`define HALF_BIT_CYCLES 250
`define WRITE_CYCLES ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: hw/spd_prot_pkg.sv */
/*
 Types shared by the two ends of the protected SPD EEPROM link.
 Assumes spd_prot_map.svh is on the include path.
*/
`default_nettype none
`include "spd_prot_map.svh"
package spd_prot_pkg;
    // Bus command kinds a host can ask its end to perform
    typedef enum logic [2:0] {
        CMD_WRITE = 3'b000,
        CMD_READ = 3'b001,
        CMD_PERM_LOCK = 3'b010,
        CMD_REV_LOCK = 3'b011,
        CMD_REV_UNLOCK = 3'b100,
        CMD_QUERY = 3'b101
    } cmd_t;

    // Which protection setting a query names
    typedef enum logic [1:0] {
        Q_PERM = 2'b00,
        Q_REV_LOCK = 2'b01,
        Q_REV_UNLOCK = 2'b10
    } query_t;
endpackage : spd_prot_pkg
`default_nettype wire

/* File: hw/spd_link_if.sv */
/*
 Two-wire link between host and EEPROM end. Both SCL and SDA are
 open drain; the resolved levels are wired-AND of the inverted enables.
 Assumes the testbench drives core_clk into the interface.
*/
`timescale 1ns/1ps
`default_nettype none
interface spd_link_if (
    input wire logic core_clk
);
    logic scl_host_oe;
    logic sda_host_oe;
    logic sda_dev_oe;
    logic scl;
    logic sda;

    // Open drain: any enable pulls the line low
    assign scl = ~scl_host_oe;
    assign sda = ~(sda_host_oe | sda_dev_oe);

    modport host (
        output scl_host_oe,
        output sda_host_oe,
        input scl,
        input sda
    );
    modport device (
        output sda_dev_oe,
        input scl,
        input sda
    );
endinterface : spd_link_if
`default_nettype wire

/* File: hw/spd_eeprom_end.sv */
/*
 EEPROM end: two-wire slave with 256-byte array and lower-half
 write protection. Assumes a link interface and a non-volatile image
 of the two protection flags (nv_*), sampled after reset release.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spd_prot_map.svh"
module spd_eeprom_end #(
    parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    spd_link_if.device link,
    input wire logic [2:0] addr_sel_pins,
    input wire logic overvoltage_level,
    input wire logic nv_perm_lock,
    input wire logic nv_rev_lock,
    output logic nv_write,
    output logic perm_locked,
    output logic rev_locked,
    output logic busy
);
    import spd_prot_pkg::*;

    //------------------------------------------------------------
    // Pin synchronisers: change counts when stages 2 and 3 agree
    //------------------------------------------------------------
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_q;
    logic sda_q;
    logic scl_d;
    logic sda_d;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[1:0], link.scl};
            sda_sync <= {sda_sync[1:0], link.sda};
            if (scl_sync[1] == scl_sync[2]) scl_q <= scl_sync[2];
            if (sda_sync[1] == sda_sync[2]) sda_q <= sda_sync[2];
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_q;
            sda_d <= sda_q;
        end
    end
    wire logic scl_rise = scl_q & ~scl_d;
    wire logic scl_fall = ~scl_q & scl_d;
    wire logic start_seen = scl_q & scl_d & sda_d & ~sda_q;
    wire logic stop_seen = scl_q & scl_d & ~sda_d & sda_q;

    //------------------------------------------------------------
    // Byte engine
    //------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SLAVE = 3'b001,
        ST_ADDR = 3'b010,
        ST_DATA = 3'b011,
        ST_SEND = 3'b100,
        ST_ACKIN = 3'b101,
        ST_IGNORE = 3'b110
    } state_t;

    state_t state;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic ack_slot;
    logic ack_drive;
    logic [7:0] mem [`MEM_BYTES];
    logic [7:0] addr_cnt;
    logic [7:0] wr_addr;
    logic is_prot;
    logic ack_rest;
    logic pend_write;
    logic pend_lock_perm;
    logic pend_lock_rev;
    logic pend_clear;
    logic loaded;
    logic [31:0] wait_cnt;

    // Classify a protection command by its three select bits
    function automatic cmd_t prot_kind(input logic [2:0] sel);
        if (sel == addr_sel_pins && !overvoltage_level)
            return CMD_PERM_LOCK;
        if (overvoltage_level && sel[2:1] == 2'b00)
            return CMD_REV_LOCK;
        if (overvoltage_level && sel[2:1] == 2'b01)
            return CMD_REV_UNLOCK;
        return CMD_READ;
    endfunction : prot_kind

    // Protection-setting address decision, shared by write and query
    function automatic logic prot_ack(input cmd_t k, input logic rd);
        if (k == CMD_READ || perm_locked) return 1'b0;
        if (rd) return !(rev_locked && k == CMD_REV_LOCK);
        return !(rev_locked && k == CMD_REV_LOCK);
    endfunction : prot_ack

    wire logic [7:0] rx_byte = shift;
    cmd_t kind;
    assign kind = prot_kind(rx_byte[3:1]);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            ack_slot <= 1'b0;
            ack_drive <= 1'b0;
            addr_cnt <= 8'h00;
            wr_addr <= 8'h00;
            is_prot <= 1'b0;
            ack_rest <= 1'b0;
            pend_write <= 1'b0;
            pend_lock_perm <= 1'b0;
            pend_lock_rev <= 1'b0;
            pend_clear <= 1'b0;
        end else if (start_seen) begin
            state <= (busy || !loaded) ? ST_IGNORE : ST_SLAVE;
            bit_cnt <= 4'h0;
            ack_slot <= 1'b0;
            ack_drive <= 1'b0;
            pend_write <= 1'b0;
        end else if (stop_seen) begin
            state <= ST_IDLE;
            ack_slot <= 1'b0;
            ack_drive <= 1'b0;
            // Commit once; a stray second STOP must not rerun it
            pend_write <= 1'b0;
        end else if (scl_rise && !ack_slot && state != ST_SEND) begin
            shift <= {shift[6:0], sda_q};
            bit_cnt <= bit_cnt + 4'h1;
        end else if (scl_rise && state == ST_SEND && ack_slot) begin
            // Host NACK ends the read; ACK asks for the next byte
            state <= sda_q ? ST_IGNORE : ST_SEND;
        end else if (scl_fall && ack_slot) begin
            ack_slot <= 1'b0;
            ack_drive <= 1'b0;
            bit_cnt <= 4'h0;
            if (state == ST_SEND) begin
                shift <= mem[addr_cnt];
                ack_drive <= ~mem[addr_cnt][7];
                addr_cnt <= addr_cnt + 8'h01;
                bit_cnt <= 4'h1;
            end
        end else if (scl_fall && state == ST_SEND && bit_cnt != 4'h0) begin
            if (bit_cnt == 4'h8) begin
                ack_slot <= 1'b1;
                ack_drive <= 1'b0;
            end else begin
                ack_drive <= ~shift[7 - bit_cnt[2:0]];
                bit_cnt <= bit_cnt + 4'h1;
            end
        end else if (scl_fall && bit_cnt == 4'h8) begin
            ack_slot <= 1'b1;
            unique case (state)
                ST_SLAVE: begin
                    if (rx_byte[7:4] == `FIX_MEMORY &&
                        rx_byte[3:1] == addr_sel_pins) begin
                        ack_drive <= 1'b1;
                        is_prot <= 1'b0;
                        state <= rx_byte[0] ? ST_SEND : ST_ADDR;
                    end else if (rx_byte[7:4] == `FIX_PROTECT) begin
                        ack_drive <= prot_ack(kind, rx_byte[0]);
                        is_prot <= 1'b1;
                        // Query answers stop after the command byte
                        ack_rest <= !rx_byte[0] && prot_ack(kind, 1'b0);
                        pend_lock_perm <= kind == CMD_PERM_LOCK;
                        pend_lock_rev <= kind == CMD_REV_LOCK;
                        pend_clear <= kind == CMD_REV_UNLOCK && rev_locked;
                        state <= ST_ADDR;
                    end else begin
                        state <= ST_IGNORE;
                    end
                end
                ST_ADDR: begin
                    // Contents are don't care for protection commands
                    ack_drive <= is_prot ? ack_rest : 1'b1;
                    if (!is_prot) begin
                        addr_cnt <= rx_byte;
                        wr_addr <= rx_byte;
                    end
                    state <= ST_DATA;
                end
                ST_DATA: begin
                    if (is_prot) begin
                        ack_drive <= ack_rest;
                        pend_write <= ack_rest;
                    end else if ((perm_locked || rev_locked) &&
                                 wr_addr <= `LOWER_HALF_TOP) begin
                        ack_drive <= 1'b0;
                    end else begin
                        ack_drive <= 1'b1;
                        mem[wr_addr] <= rx_byte;
                        // Page write wraps within its 16-byte page
                        wr_addr <= {wr_addr[7:4], wr_addr[3:0] + 4'h1};
                        addr_cnt <= {wr_addr[7:4], wr_addr[3:0] + 4'h1};
                        pend_write <= 1'b1;
                    end
                end
                default: ack_drive <= 1'b0;
            endcase
        end
    end

    //------------------------------------------------------------
    // Protection flags and write-cycle timer
    //------------------------------------------------------------
    assign nv_write = stop_seen && pend_write && is_prot &&
        (pend_lock_perm || pend_lock_rev || pend_clear);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            perm_locked <= 1'b1;
            rev_locked <= 1'b1;
            loaded <= 1'b0;
        end else if (!loaded) begin
            perm_locked <= nv_perm_lock;
            rev_locked <= nv_rev_lock;
            loaded <= 1'b1;
        end else if (stop_seen && pend_write && is_prot) begin
            if (pend_lock_perm) perm_locked <= 1'b1;
            if (pend_lock_rev) rev_locked <= 1'b1;
            if (pend_clear) rev_locked <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wait_cnt <= 32'h0;
        end else if (stop_seen && pend_write &&
                     !(is_prot && !pend_lock_perm && !pend_lock_rev &&
                       !pend_clear)) begin
            wait_cnt <= 32'(WRITE_CYCLES);
        end else if (wait_cnt != 32'h0) begin
            wait_cnt <= wait_cnt - 32'h1;
        end
    end
    assign busy = wait_cnt != 32'h0;

    assign link.sda_dev_oe = ack_drive;
endmodule : spd_eeprom_end
`default_nettype wire

/* File: hw/spd_host_end.sv */
/*
 Host end: drives two-wire commands for the protected SPD EEPROM.
 Assumes a link interface; one command at a time on req/done.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spd_prot_map.svh"
module spd_host_end #(
    parameter int HALF_BIT = `HALF_BIT_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    spd_link_if.host link,
    input wire logic req,
    input wire spd_prot_pkg::cmd_t cmd,
    input wire logic [2:0] sel,
    input wire logic [7:0] mem_addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] read_len,
    output logic ready,
    output logic done,
    output logic [2:0] acks,
    output logic [7:0] rdata,
    output logic rvalid
);
    import spd_prot_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_START = 3'b001,
        H_BITS = 3'b010,
        H_RSTART = 3'b011,
        H_STOP = 3'b100,
        H_DONE = 3'b101
    } hstate_t;

    hstate_t state;
    logic [15:0] tick;
    logic [1:0] phase;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [7:0] tx;
    logic [7:0] rx;
    logic reading;
    logic second_pass;
    logic [7:0] left;
    cmd_t cur;
    logic [2:0] cur_sel;
    logic [7:0] cur_addr;
    logic [7:0] cur_data;

    wire logic step = tick == 16'(HALF_BIT - 1);
    wire logic is_read = cur == CMD_READ;

    // First byte: memory or protection pattern, selects, direction
    function automatic logic [7:0] first_byte(input logic rd);
        if (cur == CMD_WRITE || cur == CMD_READ)
            return {`FIX_MEMORY, cur_sel, rd};
        return {`FIX_PROTECT, cur_sel, rd};
    endfunction : first_byte

    always_ff @(posedge core_clk) begin
        if (sys_rst) tick <= 16'h0;
        else if (state == H_IDLE || step) tick <= 16'h0;
        else tick <= tick + 16'h1;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= H_IDLE;
            link.scl_host_oe <= 1'b0;
            link.sda_host_oe <= 1'b0;
            phase <= 2'h0;
            bit_cnt <= 4'h0;
            byte_idx <= 2'h0;
            tx <= 8'h00;
            rx <= 8'h00;
            reading <= 1'b0;
            second_pass <= 1'b0;
            left <= 8'h00;
            cur <= CMD_WRITE;
            cur_sel <= 3'h0;
            cur_addr <= 8'h00;
            cur_data <= 8'h00;
            acks <= 3'h0;
            rdata <= 8'h00;
            rvalid <= 1'b0;
            done <= 1'b0;
        end else begin
            rvalid <= 1'b0;
            done <= 1'b0;
            unique case (state)
                H_IDLE: if (req) begin
                    cur <= cmd;
                    cur_sel <= sel;
                    cur_addr <= mem_addr;
                    cur_data <= wdata;
                    left <= read_len;
                    acks <= 3'h0;
                    second_pass <= 1'b0;
                    state <= H_START;
                end
                H_START, H_RSTART: if (step) begin
                    // Raise SCL only once the ninth-bit ACK has left SDA,
                    // then SDA falls while SCL high, then SCL low
                    if (link.scl_host_oe) begin
                        link.scl_host_oe <= !link.sda;
                    end else if (!link.sda_host_oe) begin
                        link.sda_host_oe <= 1'b1;
                    end else begin
                        link.scl_host_oe <= 1'b1;
                        tx <= first_byte(cmd_is_rd());
                        reading <= 1'b0;
                        byte_idx <= 2'h0;
                        bit_cnt <= 4'h0;
                        phase <= 2'h0;
                        state <= H_BITS;
                    end
                end
                H_BITS: if (step) begin
                    phase <= phase + 2'h1;
                    if (phase == 2'h0) begin
                        // Ninth slot: host drives ACK only when reading
                        if (bit_cnt == 4'h8)
                            link.sda_host_oe <= reading && left != 8'h1;
                        else if (reading) link.sda_host_oe <= 1'b0;
                        else link.sda_host_oe <= ~tx[7];
                    end else if (phase == 2'h1) begin
                        link.scl_host_oe <= 1'b0;
                    end else if (phase == 2'h2) begin
                        if (bit_cnt != 4'h8) rx <= {rx[6:0], link.sda};
                        else if (!reading) acks[byte_idx] <= ~link.sda;
                    end else begin
                        link.scl_host_oe <= 1'b1;
                        phase <= 2'h0;
                        if (bit_cnt != 4'h8) begin
                            tx <= {tx[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else begin
                            bit_cnt <= 4'h0;
                            next_byte();
                        end
                    end
                end
                H_STOP: if (step) begin
                    if (!link.sda_host_oe) begin
                        link.sda_host_oe <= 1'b1;
                    end else if (link.scl_host_oe) begin
                        link.scl_host_oe <= 1'b0;
                    end else begin
                        link.sda_host_oe <= 1'b0;
                        state <= H_DONE;
                    end
                end
                H_DONE: begin
                    done <= 1'b1;
                    state <= H_IDLE;
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    function automatic logic cmd_is_rd();
        return (is_read && second_pass) || cur == CMD_QUERY;
    endfunction : cmd_is_rd

    // Decide what follows a completed byte and its ninth slot
    task automatic next_byte();
        if (reading) begin
            rdata <= rx;
            rvalid <= 1'b1;
            left <= left - 8'h1;
            // Last wanted byte was NACKed; finish with STOP
            if (left == 8'h1) state <= H_STOP;
        end else if (byte_idx == 2'h0 && is_read && second_pass) begin
            reading <= 1'b1;
            if (left == 8'h0) state <= H_STOP;
        end else if (byte_idx == 2'h0) begin
            byte_idx <= 2'h1;
            tx <= cur_addr;
        end else if (byte_idx == 2'h1 && is_read) begin
            // Dummy write done; SCL stays low into the repeated START
            second_pass <= 1'b1;
            link.sda_host_oe <= 1'b0;
            state <= H_RSTART;
        end else if (byte_idx == 2'h1) begin
            byte_idx <= 2'h2;
            tx <= cur_data;
        end else begin
            state <= H_STOP;
        end
    endtask : next_byte

    assign ready = state == H_IDLE;
endmodule : spd_host_end
`default_nettype wire

/* File: sim/spd_link_monitor.sv */
/*
 Link checker for the protected SPD EEPROM pair.
 Assumes host HALF_BIT of at least 4 and plain link signals as inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module spd_link_monitor (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic scl_host_oe,
    input wire logic sda_host_oe,
    input wire logic sda_dev_oe,
    input wire logic scl,
    input wire logic sda
);
    // ------------------------------------------------------------
    // Link properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence scl_high;
        scl [*4];
    endsequence

    sequence bus_free;
        (scl && sda) [*3];
    endsequence

    // Reset must leave SCL and the device's SDA enable released
    release_in_rst_a: assert property (disable iff (1'b0)
        sys_rst && $past(sys_rst) |-> !sda_dev_oe && !scl_host_oe)
        else $error("link driven during reset");
    line_and_a: assert property (sda == !(sda_host_oe || sda_dev_oe))
        else $error("sda not wired-AND");
    dev_setup_a: assert property ($changed(sda_dev_oe) |-> !scl)
        else $error("device moved sda while scl high");
    ack_hold_a: assert property (
        $rose(scl) && sda_dev_oe |-> sda_dev_oe throughout scl_high)
        else $error("device bit not held over scl high");
    scl_width_a: assert property ($rose(scl) |-> scl_high)
        else $error("scl high too short");
    no_fight_a: assert property (scl && sda_dev_oe |-> !sda_host_oe)
        else $error("both ends drive sda");
    host_frames_a: assert property (scl && $past(scl) && $changed(sda)
        |-> !sda_dev_oe && !$past(sda_dev_oe))
        else $error("device made a start or stop");
    stop_idle_a: assert property (scl && $rose(sda) |-> bus_free)
        else $error("bus not free after stop");
endmodule : spd_link_monitor
`default_nettype wire

/* File: sim/testbench.sv */
/*
 Self-checking bench: host end and EEPROM end joined by one link.
 Assumes acks bits read 1 for ACK and sel[0] is the addr_sel_0 level.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import spd_prot_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and instances
    // ------------------------------------------------------------
    localparam logic [2:0] PINS = 3'b101;
    logic core_clk = 1'b0, sys_rst = 1'b1, req = 1'b0, ov = 1'b0;
    logic nv_perm = 1'b0, nv_rev = 1'b0;
    cmd_t cmd = CMD_WRITE;
    logic [2:0] sel = 3'h0, acks;
    logic [7:0] mem_addr = 8'h00, wdata = 8'h00, read_len = 8'h00, rdata;
    logic ready, done, rvalid, nv_write, perm_locked, rev_locked, busy;
    int n_mismatch = 0, checks = 0, n_nv = 0, n_busy = 0;
    logic [7:0] rq[$];

    initial forever #2.5 core_clk = ~core_clk;
    spd_link_if link (.core_clk(core_clk));
    spd_host_end #(.HALF_BIT(8)) u_spd_host_end (.core_clk(core_clk),
        .sys_rst(sys_rst), .link(link), .req(req), .cmd(cmd), .sel(sel),
        .mem_addr(mem_addr), .wdata(wdata), .read_len(read_len),
        .ready(ready), .done(done), .acks(acks), .rdata(rdata),
        .rvalid(rvalid));
    // Short write cycle keeps the run brief
    spd_eeprom_end #(.WRITE_CYCLES(20)) u_spd_eeprom_end (
        .core_clk(core_clk), .sys_rst(sys_rst), .link(link),
        .addr_sel_pins(PINS), .overvoltage_level(ov),
        .nv_perm_lock(nv_perm), .nv_rev_lock(nv_rev), .nv_write(nv_write),
        .perm_locked(perm_locked), .rev_locked(rev_locked), .busy(busy));
    spd_link_monitor u_spd_link_monitor (.core_clk(core_clk),
        .sys_rst(sys_rst),
        .scl_host_oe(link.scl_host_oe), .sda_host_oe(link.sda_host_oe),
        .sda_dev_oe(link.sda_dev_oe), .scl(link.scl), .sda(link.sda));

    always @(posedge core_clk) begin
        if (rvalid === 1'b1) rq.push_back(rdata);
        if (nv_write === 1'b1) n_nv <= n_nv + 1;
        if (busy === 1'b1) n_busy <= n_busy + 1;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic report(input string nm, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : report
    task automatic cmp3(input string nm, input logic [2:0] e, g);
        report(nm, {5'h00, e}, {5'h00, g});
    endtask : cmp3
    task automatic cmp8(input string nm, input logic [7:0] e, g);
        report(nm, e, g);
    endtask : cmp8
    task automatic cmp1(input string nm, input logic e, g);
        report(nm, {7'h00, e}, {7'h00, g});
    endtask : cmp1
    task automatic run(input cmd_t c, input logic [2:0] s, input logic o,
        input logic [7:0] a, d, n);
        int i;
        rq.delete();
        @(negedge core_clk);
        for (i = 0; i < 100 && ready !== 1'b1; i++) @(negedge core_clk);
        if (i == 100) n_mismatch++;
        cmd = c;
        sel = s;
        ov = o;
        mem_addr = a;
        wdata = d;
        read_len = n;
        req = 1'b1;
        @(negedge core_clk);
        req = 1'b0;
        for (i = 0; i < 30000 && done !== 1'b1; i++) @(negedge core_clk);
        if (i == 30000) n_mismatch++;
        // STOP reaches the device through its pin synchroniser, so busy
        // only rises a few cycles after done
        repeat (8) @(negedge core_clk);
        for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge core_clk);
        if (i == 200) n_mismatch++;
    endtask : run
    task automatic ack(input cmd_t c, input logic [2:0] s, input logic o,
        input logic [7:0] a, input logic [2:0] e);
        run(c, s, o, a, 8'h5a, 8'h00);
        cmp3("acks", e, acks);
    endtask : ack
    // Expected command-byte acks: bit0 perm, bit1 lock, bit2 unlock
    task automatic qry(input logic [2:0] e);
        ack(CMD_QUERY, PINS, 1'b0, 8'h00, {2'b00, e[0]});
        ack(CMD_QUERY, 3'b001, 1'b1, 8'h00, {2'b00, e[1]});
        ack(CMD_QUERY, 3'b011, 1'b1, 8'h00, {2'b00, e[2]});
    endtask : qry
    task automatic wrap_up;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        // Nearly three times the expected length of the whole sequence
        #400_000;
        n_mismatch++;
        wrap_up;
    end

    initial begin
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        ack(CMD_WRITE, PINS, 1'b0, 8'h10, 3'b111);
        cmp8("busy_cycles", 8'h14, 8'(n_busy));
        run(CMD_WRITE, PINS, 1'b0, 8'hff, 8'hc3, 8'h00);
        run(CMD_WRITE, PINS, 1'b0, 8'h00, 8'h11, 8'h00);
        run(CMD_READ, PINS, 1'b0, 8'hff, 8'h00, 8'h02);
        cmp8("rdata", 8'hc3, rq[0]);
        cmp8("rdata", 8'h11, rq[1]);
        qry(3'b111);
        ack(CMD_REV_LOCK, 3'b001, 1'b0, 8'h00, 3'b000);
        ack(CMD_REV_LOCK, 3'b001, 1'b1, 8'h3c, 3'b111);
        cmp1("rev_locked", 1'b1, rev_locked);
        run(CMD_WRITE, PINS, 1'b0, 8'h10, 8'ha5, 8'h00);
        cmp3("acks", 3'b011, acks);
        ack(CMD_WRITE, PINS, 1'b0, 8'h90, 3'b111);
        run(CMD_READ, PINS, 1'b0, 8'h10, 8'h00, 8'h01);
        cmp8("rdata", 8'h5a, rq[0]);
        ack(CMD_REV_LOCK, 3'b001, 1'b1, 8'h00, 3'b000);
        qry(3'b101);
        ack(CMD_REV_UNLOCK, 3'b011, 1'b1, 8'hc3, 3'b111);
        cmp1("rev_locked", 1'b0, rev_locked);
        ack(CMD_REV_UNLOCK, 3'b011, 1'b1, 8'h00, 3'b111);
        cmp8("busy_cycles", 8'h78, 8'(n_busy));
        ack(CMD_REV_LOCK, 3'b001, 1'b1, 8'h00, 3'b111);
        ack(CMD_PERM_LOCK, PINS, 1'b0, 8'h00, 3'b111);
        cmp1("perm_locked", 1'b1, perm_locked);
        cmp8("nv_writes", 8'h04, 8'(n_nv));
        ack(CMD_PERM_LOCK, PINS, 1'b0, 8'h00, 3'b000);
        ack(CMD_REV_LOCK, 3'b001, 1'b1, 8'h00, 3'b000);
        ack(CMD_REV_UNLOCK, 3'b011, 1'b1, 8'h00, 3'b000);
        qry(3'b000);
        ack(CMD_WRITE, PINS, 1'b0, 8'h7f, 3'b011);
        ack(CMD_WRITE, PINS, 1'b0, 8'h80, 3'b111);
        // Second reset with the NV image showing a permanent lock
        @(negedge core_clk);
        sys_rst = 1'b1;
        nv_perm = 1'b1;
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge core_clk);
        cmp1("perm_locked", 1'b1, perm_locked);
        cmp1("rev_locked", 1'b0, rev_locked);
        ack(CMD_WRITE, PINS, 1'b0, 8'h00, 3'b011);
        run(CMD_READ, PINS, 1'b0, 8'h00, 8'h00, 8'h01);
        cmp8("rdata", 8'h11, rq[0]);
        wrap_up;
    end
endmodule : testbench
`default_nettype wire
